// ==== chgi2c_pkg.sv ====
package chgi2c_pkg;
   // ==========================================================
   // Bus addressing
   localparam logic [6:0] DEV_ADDR = 7'h48;
   localparam logic [3:0] REG_RAIL_IDX = 4'h9;
   localparam logic [3:0] REG_ALERT_IDX = 4'ha;
   localparam int MAX_BIT_RATE_KBPS = 400;
   // ==========================================================
   // Field positions and reset values
   localparam int RAIL_V_LSB = 3;
   localparam int PRE_I_LSB = 0;
   localparam logic [7:0] REG_RAIL_RST = 8'h39;
   localparam logic [7:0] REG_ALERT_RST = 8'h3e;
   localparam int AL_OUT_BIT = 5;
   localparam int AL_WAKE_BIT = 4;
   localparam int AL_HOLD_BIT = 3;
   localparam int AL_PULSE_BIT = 2;
   localparam int AL_SHIP_BIT = 1;
   localparam int AL_SUPPLY_BIT = 0;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 125000000;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam int T_WAKE_SHORT_MS = 50;
   localparam int T_WAKE_LONG_MS = 2000;
   localparam int T_HOLD_SHORT_MS = 8000;
   localparam int T_HOLD_LONG_MS = 16000;
   localparam int T_PULSE_SHORT_MS = 2000;
   localparam int T_PULSE_LONG_MS = 4000;
   localparam int MS_W = 15;
   // ==========================================================
   // Types
   typedef struct packed {
      logic [3:0] load_rail_voltage_code;
      logic [2:0] precharge_current_code;
      logic alert_output_gate;
      logic alert_low_wake_gate;
      logic alert_hold_reset_delay;
      logic rail_reset_pulse_length;
      logic alert_wake_hold_time;
      logic supply_good_wake_time;
   } chgi2c_cfg_s;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ACK_A = 9'h004,
      ST_PTR = 9'h008,
      ST_ACK_P = 9'h010,
      ST_WDATA = 9'h020,
      ST_ACK_W = 9'h040,
      ST_RDATA = 9'h080,
      ST_RACK = 9'h100
   } chgi2c_st_e;
endpackage : chgi2c_pkg

// ==== chgi2c_sync.sv ====
`timescale 1ns/10ps
module chgi2c_sync (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [2:0] pin_in,
   output logic [2:0] level
);
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] s3_reg;

   // A change is accepted only once the second and third stage agree
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s1_reg <= 3'h7;
         s2_reg <= 3'h7;
         s3_reg <= 3'h7;
         level <= 3'h7;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level <= (s2_reg & s3_reg) | (~(s2_reg ^ s3_reg) & s3_reg)
                  | ((s2_reg ^ s3_reg) & level);
      end
   end
endmodule : chgi2c_sync

// ==== chgi2c_port.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Data changes only while serial clock low
// - Eight bits MSB first, then acknowledge slot
// - Device acknowledges address, pointer, write bytes
// - Works at any rate up to 400 kbit/s
// - Answers only addresses 90h write, 91h read
// - Pointer low nibble selects register, acknowledged
// - Single or continuous write bytes, each acknowledged
// - Read: pointer write, restart, read byte, stop
// - Output gate clear masks alert signalling
// - Wake gate clear ignores external alert low
// - Alert held 8 s/16 s resets load rail
// - Rail reset lasts 2 s or 4 s
// - Alert held 50 ms/2 s leaves shipping
// - Supply good 50 ms/2 s leaves shipping
module chgi2c_port #(
   parameter int MS_TICK_CYCLES = chgi2c_pkg::MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic alert_in,
   output logic alert_out,
   output logic alert_oe_n,
   input wire logic alert_event,
   input wire logic watchdog_overflow,
   input wire logic supply_good,
   input wire logic ship_mode,
   output logic ship_exit,
   output logic rail_reset,
   output chgi2c_pkg::chgi2c_cfg_s cfg
);
   // ==========================================================
   // Pin sampling
   logic [2:0] lvl;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   chgi2c_sync u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pin_in({alert_in, sda_in, scl_in}),
      .level(lvl)
   );

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= lvl[0];
         sda_prev_reg <= lvl[1];
      end
   end

   // Data sampled on clock edges only; data edges under high clock
   // are framing, which keeps the bit path rate-independent
   assign scl_rise = lvl[0] & ~scl_prev_reg;
   assign scl_fall = ~lvl[0] & scl_prev_reg;
   assign start_det = lvl[0] & scl_prev_reg & sda_prev_reg & ~lvl[1];
   assign stop_det = lvl[0] & scl_prev_reg & ~sda_prev_reg & lvl[1];

   // ==========================================================
   // Register file
   logic [7:0] rail_reg;
   logic [7:0] alert_reg;
   logic wr_en;
   logic [3:0] ptr_reg;
   logic [7:0] shift_reg;
   logic [7:0] rx_byte;

   function automatic logic [7:0] rd_byte(input logic [3:0] idx,
                                          input logic [7:0] r9,
                                          input logic [7:0] ra);
      case (idx)
         chgi2c_pkg::REG_RAIL_IDX: rd_byte = r9 & 8'h7f;
         chgi2c_pkg::REG_ALERT_IDX: rd_byte = ra & 8'h3f;
         default: rd_byte = 8'h00;
      endcase
   endfunction : rd_byte

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rail_reg <= chgi2c_pkg::REG_RAIL_RST;
         alert_reg <= chgi2c_pkg::REG_ALERT_RST;
      end else if (wr_en) begin
         // Reserved bits always hold zero
         if (ptr_reg == chgi2c_pkg::REG_RAIL_IDX)
            rail_reg <= rx_byte & 8'h7f;
         if (ptr_reg == chgi2c_pkg::REG_ALERT_IDX)
            alert_reg <= rx_byte & 8'h3f;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg <= '0;
      end else begin
         cfg.load_rail_voltage_code <= rail_reg[chgi2c_pkg::RAIL_V_LSB +: 4];
         cfg.precharge_current_code <= rail_reg[chgi2c_pkg::PRE_I_LSB +: 3];
         cfg.alert_output_gate <= alert_reg[chgi2c_pkg::AL_OUT_BIT];
         cfg.alert_low_wake_gate <= alert_reg[chgi2c_pkg::AL_WAKE_BIT];
         cfg.alert_hold_reset_delay <= alert_reg[chgi2c_pkg::AL_HOLD_BIT];
         cfg.rail_reset_pulse_length <= alert_reg[chgi2c_pkg::AL_PULSE_BIT];
         cfg.alert_wake_hold_time <= alert_reg[chgi2c_pkg::AL_SHIP_BIT];
         cfg.supply_good_wake_time <= alert_reg[chgi2c_pkg::AL_SUPPLY_BIT];
      end
   end

   // ==========================================================
   // Serial target
   chgi2c_pkg::chgi2c_st_e st_reg;
   logic [3:0] cnt_reg;
   logic rw_reg;
   logic nack_reg;
   logic [7:0] tx_byte;

   assign rx_byte = {shift_reg[6:0], lvl[1]};
   assign wr_en = scl_rise & (st_reg == chgi2c_pkg::ST_WDATA)
                  & (cnt_reg == 4'h7);
   assign tx_byte = rd_byte(ptr_reg, rail_reg, alert_reg);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_reg <= chgi2c_pkg::ST_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 4'h0;
         rw_reg <= 1'b0;
         nack_reg <= 1'b1;
         sda_oe_n <= 1'b1;
      end else if (start_det) begin
         st_reg <= chgi2c_pkg::ST_ADDR;
         cnt_reg <= 4'h0;
         sda_oe_n <= 1'b1;
      end else if (stop_det) begin
         st_reg <= chgi2c_pkg::ST_IDLE;
         sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
         case (st_reg)
            chgi2c_pkg::ST_ADDR, chgi2c_pkg::ST_PTR: begin
               shift_reg <= rx_byte;
               cnt_reg <= cnt_reg + 4'h1;
               if (st_reg == chgi2c_pkg::ST_PTR && cnt_reg == 4'h7)
                  ptr_reg <= rx_byte[3:0];
            end
            chgi2c_pkg::ST_WDATA: begin
               shift_reg <= rx_byte;
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == 4'h7)
                  ptr_reg <= ptr_reg + 4'h1;
            end
            chgi2c_pkg::ST_RDATA: cnt_reg <= cnt_reg + 4'h1;
            chgi2c_pkg::ST_RACK: nack_reg <= lvl[1];
            default: cnt_reg <= cnt_reg;
         endcase
      end else if (scl_fall) begin
         case (st_reg)
            chgi2c_pkg::ST_ADDR: begin
               if (cnt_reg == 4'h8) begin
                  if (shift_reg[7:1] == chgi2c_pkg::DEV_ADDR) begin
                     rw_reg <= shift_reg[0];
                     sda_oe_n <= 1'b0;
                     st_reg <= chgi2c_pkg::ST_ACK_A;
                  end else begin
                     st_reg <= chgi2c_pkg::ST_IDLE;
                  end
               end
            end
            chgi2c_pkg::ST_PTR, chgi2c_pkg::ST_WDATA: begin
               if (cnt_reg == 4'h8) begin
                  sda_oe_n <= 1'b0;
                  st_reg <= (st_reg == chgi2c_pkg::ST_PTR) ?
                            chgi2c_pkg::ST_ACK_P : chgi2c_pkg::ST_ACK_W;
               end
            end
            chgi2c_pkg::ST_ACK_A, chgi2c_pkg::ST_RACK: begin
               cnt_reg <= 4'h0;
               if (st_reg == chgi2c_pkg::ST_ACK_A && !rw_reg) begin
                  sda_oe_n <= 1'b1;
                  st_reg <= chgi2c_pkg::ST_PTR;
               end else if (st_reg == chgi2c_pkg::ST_RACK && nack_reg) begin
                  // Host declined more data; wait for stop or restart
                  sda_oe_n <= 1'b1;
                  st_reg <= chgi2c_pkg::ST_IDLE;
               end else begin
                  sda_oe_n <= tx_byte[7];
                  shift_reg <= {tx_byte[6:0], 1'b0};
                  ptr_reg <= ptr_reg + 4'h1;
                  st_reg <= chgi2c_pkg::ST_RDATA;
               end
            end
            chgi2c_pkg::ST_ACK_P, chgi2c_pkg::ST_ACK_W: begin
               sda_oe_n <= 1'b1;
               cnt_reg <= 4'h0;
               st_reg <= chgi2c_pkg::ST_WDATA;
            end
            chgi2c_pkg::ST_RDATA: begin
               if (cnt_reg == 4'h8) begin
                  sda_oe_n <= 1'b1;
                  st_reg <= chgi2c_pkg::ST_RACK;
               end else begin
                  sda_oe_n <= shift_reg[7];
                  shift_reg <= {shift_reg[6:0], 1'b0};
               end
            end
            default: st_reg <= chgi2c_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Alert pin and shipping timers
   function automatic logic [14:0] pick_ms(input logic sel,
                                           input int t0,
                                           input int t1);
      pick_ms = sel ? t1[14:0] : t0[14:0];
   endfunction : pick_ms

   logic [16:0] tick_cnt_reg;
   logic tick;
   logic [14:0] al_ms_reg;
   logic [14:0] sg_ms_reg;
   logic [14:0] pulse_ms_reg;
   logic ext_low;
   logic [14:0] hold_lim;
   logic [14:0] wake_lim;
   logic [14:0] sup_lim;
   logic [14:0] pulse_lim;

   assign tick = (tick_cnt_reg == 17'(MS_TICK_CYCLES - 1));
   // Our own drive on the pin must not count as a host hold
   assign ext_low = ~lvl[2] & alert_oe_n & cfg.alert_low_wake_gate;
   assign hold_lim = pick_ms(cfg.alert_hold_reset_delay,
      chgi2c_pkg::T_HOLD_SHORT_MS, chgi2c_pkg::T_HOLD_LONG_MS);
   assign wake_lim = pick_ms(cfg.alert_wake_hold_time,
      chgi2c_pkg::T_WAKE_SHORT_MS, chgi2c_pkg::T_WAKE_LONG_MS);
   assign sup_lim = pick_ms(cfg.supply_good_wake_time,
      chgi2c_pkg::T_WAKE_SHORT_MS, chgi2c_pkg::T_WAKE_LONG_MS);
   assign pulse_lim = pick_ms(cfg.rail_reset_pulse_length,
      chgi2c_pkg::T_PULSE_SHORT_MS, chgi2c_pkg::T_PULSE_LONG_MS);

   always_ff @(posedge clk_sys) begin
      if (sys_rst || tick)
         tick_cnt_reg <= 17'h00000;
      else
         tick_cnt_reg <= tick_cnt_reg + 17'h00001;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         alert_oe_n <= 1'b1;
         alert_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         alert_oe_n <= ~(alert_event & cfg.alert_output_gate);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         al_ms_reg <= 15'h0000;
         sg_ms_reg <= 15'h0000;
         pulse_ms_reg <= 15'h0000;
         ship_exit <= 1'b0;
         rail_reset <= 1'b0;
      end else begin
         ship_exit <= 1'b0;
         if (!ext_low)
            al_ms_reg <= 15'h0000;
         else if (tick && al_ms_reg != 15'h7fff)
            al_ms_reg <= al_ms_reg + 15'h0001;
         if (!supply_good)
            sg_ms_reg <= 15'h0000;
         else if (tick && sg_ms_reg != 15'h7fff)
            sg_ms_reg <= sg_ms_reg + 15'h0001;
         if (ship_mode && tick && ((ext_low && al_ms_reg + 15'h0001 == wake_lim)
             || (supply_good && sg_ms_reg + 15'h0001 == sup_lim)))
            ship_exit <= 1'b1;
         if (watchdog_overflow
             || (ext_low && tick && al_ms_reg + 15'h0001 == hold_lim)) begin
            rail_reset <= 1'b1;
            pulse_ms_reg <= 15'h0000;
         end else if (rail_reset && tick) begin
            pulse_ms_reg <= pulse_ms_reg + 15'h0001;
            if (pulse_ms_reg + 15'h0001 == pulse_lim)
               rail_reset <= 1'b0;
         end
      end
   end
endmodule : chgi2c_port

// ==== chgi2c_host.sv ====
`timescale 1ns/10ps
// ==========================================================
// Bus controller model: open drain, released lines float high
module chgi2c_host (
   input wire logic clk,
   input wire logic sda_pin,
   output logic scl_low,
   output logic sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   // One bit is 20 system cycles: 160 ns serial clock period
   task automatic bit_io(input logic b, output logic r);
      sda_low = ~b;
      wt(5);
      scl_low = 1'b0;
      wt(10);
      r = sda_pin;
      scl_low = 1'b1;
      wt(5);
   endtask : bit_io
   // Also serves as repeated start when entered with the clock low
   task automatic start;
      sda_low = 1'b0;
      wt(5);
      scl_low = 1'b0;
      wt(10);
      sda_low = 1'b1;
      wt(10);
      scl_low = 1'b1;
      wt(5);
   endtask : start
   task automatic stop;
      sda_low = 1'b1;
      wt(5);
      scl_low = 1'b0;
      wt(10);
      sda_low = 1'b0;
      wt(10);
   endtask : stop
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wbyte
   task automatic rbyte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(1'b1, r);
   endtask : rbyte
endmodule : chgi2c_host

// ==== chgi2c_port_chk.sv ====
`timescale 1ns/10ps
module chgi2c_port_chk #(
   parameter int MS_TICK_CYCLES = chgi2c_pkg::MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic alert_out,
   input wire logic alert_oe_n,
   input wire logic alert_event,
   input wire logic watchdog_overflow,
   input wire logic ship_mode,
   input wire logic ship_exit,
   input wire logic rail_reset,
   input wire chgi2c_pkg::chgi2c_cfg_s cfg
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Checks
   a_reset_quiet: assert property ($fell(sys_rst) |-> sda_oe_n &&
      alert_oe_n && !ship_exit && !rail_reset)
      else $error("outputs active right after reset");
   a_cfg_default: assert property ($fell(sys_rst) |-> ##2
      cfg == {4'h7, 3'h1, 6'h3e}) else $error("cfg not at defaults");
   a_pins_low: assert property (sda_out == 1'b0 && alert_out == 1'b0)
      else $error("open drain pin driven high");
   a_data_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data drive changed with clock high");
   a_alert_idle: assert property (!alert_event |=> alert_oe_n)
      else $error("alert driven without event");
   a_alert_mask: assert property (!cfg.alert_output_gate ##1
      !cfg.alert_output_gate |-> alert_oe_n)
      else $error("alert driven while masked");
   a_ship_pulse: assert property (ship_exit |=> !ship_exit)
      else $error("ship exit longer than one cycle");
   a_ship_mode: assert property (ship_exit |-> $past(ship_mode))
      else $error("ship exit outside shipping mode");
   a_wdog_rail: assert property (watchdog_overflow |-> ##[1:3]
      rail_reset) else $error("no rail reset after overflow");
   a_rail_len: assert property ($rose(rail_reset) |-> rail_reset[*8])
      else $error("rail reset too short");
endmodule : chgi2c_port_chk

bind chgi2c_port chgi2c_port_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_chk (
   .clk_sys(clk_sys),
   .sys_rst(sys_rst),
   .scl_in(scl_in),
   .sda_out(sda_out),
   .sda_oe_n(sda_oe_n),
   .alert_out(alert_out),
   .alert_oe_n(alert_oe_n),
   .alert_event(alert_event),
   .watchdog_overflow(watchdog_overflow),
   .ship_mode(ship_mode),
   .ship_exit(ship_exit),
   .rail_reset(rail_reset),
   .cfg(cfg)
);

// ==== chgi2c_port_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   err_total++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module chgi2c_port_tb_top;
   logic clk_sys, sys_rst, alert_event, watchdog_overflow;
   logic supply_good, ship_mode, alert_low, scl_low, sda_low;
   // Side-band levels: event, overflow, supply good, shipping, alert low
   logic [4:0] side_in;
   localparam logic [4:0] SB_EVT = 5'h10;
   localparam logic [4:0] SB_WDOG = 5'h08;
   localparam logic [4:0] SB_SUP = 5'h04;
   localparam logic [4:0] SB_SHIP = 5'h02;
   localparam logic [4:0] SB_AL = 5'h01;
   logic sda_out, sda_oe_n, alert_out, alert_oe_n, ship_exit, rail_reset;
   logic scl, sda, alert_pin;
   chgi2c_pkg::chgi2c_cfg_s cfg;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   // Wired-and lines with pull-ups
   assign scl = ~scl_low;
   assign sda = ~sda_low & (sda_oe_n | sda_out);
   assign alert_pin = ~alert_low & (alert_oe_n | alert_out);
   assign {alert_event, watchdog_overflow, supply_good} = side_in[4:2];
   assign {ship_mode, alert_low} = side_in[1:0];
   chgi2c_host h (.clk(clk_sys), .sda_pin(sda), .scl_low(scl_low),
      .sda_low(sda_low));
   chgi2c_port #(.MS_TICK_CYCLES(10)) dut (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .alert_in(alert_pin), .alert_out(alert_out),
      .alert_oe_n(alert_oe_n), .alert_event(alert_event),
      .watchdog_overflow(watchdog_overflow), .supply_good(supply_good),
      .ship_mode(ship_mode), .ship_exit(ship_exit),
      .rail_reset(rail_reset), .cfg(cfg));
   initial clk_sys = 1'b0;
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         conclude();
      end
   end
   // ==========================================================
   // Bus helpers
   task automatic side(input logic [4:0] m, input logic v);
      side_in = v ? (side_in | m) : (side_in & ~m);
   endtask : side
   task automatic wr(input logic [7:0] p, d0, d1, input int n);
      logic a;
      h.start();
      h.wbyte(8'h90, a); `CHK("ack addr", 1'b1, a)
      h.wbyte(p, a); `CHK("ack ptr", 1'b1, a)
      h.wbyte(d0, a); `CHK("ack data", 1'b1, a)
      if (n > 1) begin
         h.wbyte(d1, a); `CHK("ack data1", 1'b1, a)
      end
      h.stop();
   endtask : wr
   task automatic rd(input logic [7:0] p, e);
      logic a;
      logic [7:0] d;
      h.start();
      h.wbyte(8'h90, a); `CHK("rd ack", 1'b1, a)
      h.wbyte(p, a);
      h.start();
      h.wbyte(8'h91, a); `CHK("rd ack r", 1'b1, a)
      h.rbyte(d);
      h.stop();
      `CHK("read data", e, d)
   endtask : rd
   // Waits at most lim cycles; a missing pulse ends with n equal to lim
   task automatic count_ship(input int lo, hi, lim);
      int n = 0;
      while (ship_exit !== 1'b1 && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("ship time ok", 1'b1, n >= lo && n <= hi)
   endtask : count_ship
   // ==========================================================
   // Scenarios
   task automatic t_defaults;
      rd(8'h09, 8'h39);
      rd(8'h0a, 8'h3e);
      `CHK("cfg rail", 4'h7, cfg.load_rail_voltage_code)
      $display("test defaults done");
   endtask : t_defaults
   task automatic t_burst;
      // Upper pointer nibble must be ignored; bit 7 is reserved
      wr(8'hf9, 8'hd5, 8'h10, 2);
      rd(8'h09, 8'h55);
      rd(8'h0a, 8'h10);
      `CHK("cfg pre", 3'h5, cfg.precharge_current_code)
      $display("test burst done");
   endtask : t_burst
   task automatic t_bad_addr;
      logic a;
      h.start();
      h.wbyte(8'h92, a); `CHK("no ack", 1'b0, a)
      h.stop();
      rd(8'h09, 8'h55);
      $display("test address done");
   endtask : t_bad_addr
   task automatic t_alert;
      side(SB_EVT, 1'b1);
      h.wt(4);
      `CHK("masked", 1'b1, alert_oe_n)
      wr(8'h0a, 8'h30, 8'h00, 1);
      h.wt(4);
      `CHK("alert on", 1'b0, alert_oe_n)
      side(SB_EVT, 1'b0);
      h.wt(4);
      $display("test alert done");
   endtask : t_alert
   task automatic t_ship;
      side(SB_SHIP | SB_AL, 1'b1);
      count_ship(480, 520, 540);
      side(SB_AL, 1'b0);
      h.wt(20);
      side(SB_SUP, 1'b1);
      count_ship(480, 520, 540);
      side(SB_SUP, 1'b0);
      wr(8'h0a, 8'h20, 8'h00, 1);
      side(SB_AL, 1'b1);
      // Wake gate cleared: no exit may come in the whole window
      count_ship(5000, 5000, 5000);
      side(SB_SHIP | SB_AL, 1'b0);
      $display("test shipping done");
   endtask : t_ship
   task automatic t_rail;
      int m = 0;
      side(SB_WDOG, 1'b1);
      h.wt(1);
      side(SB_WDOG, 1'b0);
      h.wt(4);
      while (rail_reset === 1'b1 && m < 21000) begin
         @(negedge clk_sys);
         m++;
      end
      `CHK("rail len ok", 1'b1, m >= 19970 && m <= 20010)
      $display("test rail done");
   endtask : t_rail
   task automatic conclude;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   initial begin
      sys_rst = 1'b1;
      side_in = 5'h00;
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      h.wt(6);
      t_defaults();
      t_burst();
      t_bad_addr();
      t_alert();
      t_ship();
      t_rail();
      conclude();
   end
endmodule : chgi2c_port_tb_top
